// ==== lieb_pkg.sv ====
// Package for the link interrupt event bank: offsets, bit positions, reset values
`default_nettype none
package lieb_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CHAN_LOW_SET_OFS  = 8'h78;
  localparam logic [7:0] CHAN_LOW_CLR_OFS  = 8'h7c;
  localparam logic [7:0] EVENT_SET_OFS     = 8'h80;
  localparam logic [7:0] EVENT_CLR_OFS     = 8'h84;
  localparam logic [7:0] EVENT_MASK_OFS    = 8'h88;
  localparam logic [7:0] IRQ_STAT_OFS      = 8'h90;
  localparam logic [7:0] IRQ_CLR_OFS       = 8'h94;
  localparam logic [7:0] IRQ_EN_OFS        = 8'h98;
  localparam logic [7:0] CTRL_OFS          = 8'h9c;

  // ---------------------------------------------------------------
  // Event bit positions
  // ---------------------------------------------------------------
  localparam int SOFT_BIT     = 29;
  localparam int TARDY_BIT    = 27;
  localparam int PHYREG_BIT   = 26;
  localparam int OVERRUN_BIT  = 25;
  localparam int FATAL_BIT    = 24;
  localparam int MISMATCH_BIT = 23;
  localparam int ISO_RX_BIT   = 7;
  localparam int ISO_TX_BIT   = 6;

  // Writable latched event bits (31, 30, 28 reserved)
  localparam logic [31:0] EVENT_LATCH_MASK = 32'h2f80_0000;

  // Control register fields
  localparam int CTRL_TARDY_EN_BIT = 0;
  localparam int CTRL_ROOT_EN_BIT  = 1;

  // Reset values
  localparam logic [31:0] CHAN_RESET  = 32'h0000_0000;
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;

  // Interrupt status layout, one bit per hardware event plus one for the soft bit
  localparam int IRQ_W = 6;

  // Cycle timer compare fields
  typedef struct packed {
    logic [6:0]  secs;
    logic [12:0] cnt;
  } lieb_cyc_time_s;

  // Hardware event source levels
  typedef struct packed {
    logic rx_fifo_pending;
    logic phys_resp_busy;
    logic tardy_ack_sent;
    logic phy_reg_byte_arrived;
    logic cycle_overrun;
    logic fatal_stop;
    logic cycle_start_rcvd;
  } lieb_src_s;

endpackage

`default_nettype wire

// ==== lieb_top.sv ====
// Interrupt event bank and low isochronous receive channel mask, Wishbone slave
// ---------------------------------------------------------------
// Functional notes
// [RQ1] Channel mask bit n enables isochronous receive on channel n, zero blocks it.
// [RQ2] Channel mask has set and clear addresses; either address reads the mask.
// [RQ3] Event bit sets on source rising edge or a one written at set address.
// [RQ4] Event bit clears only by a one written at the clear address.
// [RQ5] Event read returns latched events ANDed with the event mask.
// [RQ6] Event bits 31, 30 and 28 are reserved and read zero.
// [RQ7] Bit 29 is software-only, set and cleared by software alone.
// [RQ8] Bit 27 sets when late ack enable and fifo, busy or tardy ack holds.
// [RQ9] Bit 26 sets on PHY register byte arrival; byte shown in bits 23..16. Here the byte goes only to phy_reg_data_o.
// [RQ10] With cycle root enabled, bit 25 sets when a cycle overruns 125 us.
// [RQ11] A cycle overrun event clears the cycle root enable control.
// [RQ12] Bit 24 sets when an error stops any subunit.
// [RQ13] While bit 24 is set, faulting contexts' normal events are blocked.
// [RQ14] Bit 23 sets when received cycle start time differs from local timer.
// [RQ15] Iso summary bits 7 and 6 are unlatched OR of masked context events.
// [RQ16] Zeros written at set or clear addresses, and reserved bits, change nothing.
// ---------------------------------------------------------------
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module lieb_top #(
  parameter int CTX_N = 4
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Event sources
  input  wire lieb_pkg::lieb_src_s    src_i,
  input  wire logic [7:0]             phy_reg_byte_i,
  input  wire lieb_pkg::lieb_cyc_time_s rx_cycle_time_i,
  input  wire lieb_pkg::lieb_cyc_time_s local_cycle_time_i,
  input  wire logic [CTX_N-1:0]       ctx_fault_i,
  input  wire logic [CTX_N-1:0]       ctx_event_i,
  input  wire logic [31:0]            iso_rx_ctx_masked_i,
  input  wire logic [31:0]            iso_tx_ctx_masked_i,
  // Block outputs
  output logic [31:0]                 iso_rx_chan_enable_bit_o,
  output logic                        cycle_root_enable_o,
  output logic                        late_ack_event_enable_o,
  output logic [7:0]                  phy_reg_data_o,
  output logic [CTX_N-1:0]            ctx_event_o,
  output logic                        irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0]      chan_r;
  logic [31:0]      event_r;
  logic [31:0]      mask_r;
  logic [CTX_N-1:0] fault_ctx_r;
  logic [1:0]       ctrl_r;
  logic [lieb_pkg::IRQ_W-1:0] irq_stat_r;
  logic [lieb_pkg::IRQ_W-1:0] irq_en_r;
  lieb_pkg::lieb_src_s src_q_r;
  logic [31:0]      wmask;
  logic             wr_stb;
  logic             hw_tardy;
  logic             hw_phy;
  logic             hw_over;
  logic             hw_fatal;
  logic             hw_mis;
  logic [31:0]      hw_set;
  logic [lieb_pkg::IRQ_W-1:0] hw_vec;
  logic [31:0]      rd_nxt;

  // Expand byte selects into a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Test for a write at a given offset
  function automatic logic wr_at(input logic [7:0] adr, input logic [7:0] ofs, input logic stb);
    wr_at = stb && (adr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One write per request cycle without ack; a request held past ack writes again
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign wmask  = wb_dat_i & sel_mask(wb_sel_i);

  // Ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // ---------------------------------------------------------------
  // Edge detection of sources
  // ---------------------------------------------------------------
  // Last cycle's source levels; cleared by reset, so a source already high at reset release reads as an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q_r <= '0;
    end else begin
      src_q_r <= src_i;
    end
  end

  // Asserting edges of each event condition
  assign hw_tardy = ctrl_r[lieb_pkg::CTRL_TARDY_EN_BIT] &&                       // RQ8
                    ((src_i.rx_fifo_pending && !src_q_r.rx_fifo_pending) ||
                     (src_i.phys_resp_busy && !src_q_r.phys_resp_busy) ||
                     (src_i.tardy_ack_sent && !src_q_r.tardy_ack_sent));
  assign hw_phy   = src_i.phy_reg_byte_arrived && !src_q_r.phy_reg_byte_arrived;  // RQ9
  assign hw_over  = ctrl_r[lieb_pkg::CTRL_ROOT_EN_BIT] &&
                    src_i.cycle_overrun && !src_q_r.cycle_overrun;                // RQ10
  assign hw_fatal = src_i.fatal_stop && !src_q_r.fatal_stop;                      // RQ12
  assign hw_mis   = src_i.cycle_start_rcvd && !src_q_r.cycle_start_rcvd &&
                    (rx_cycle_time_i != local_cycle_time_i);                      // RQ14

  // Hardware set vector; bit 29 has no source
  always_comb begin
    hw_set = '0;                                                                  // RQ7
    hw_set[lieb_pkg::TARDY_BIT]    = hw_tardy;
    hw_set[lieb_pkg::PHYREG_BIT]   = hw_phy;
    hw_set[lieb_pkg::OVERRUN_BIT]  = hw_over;
    hw_set[lieb_pkg::FATAL_BIT]    = hw_fatal;
    hw_set[lieb_pkg::MISMATCH_BIT] = hw_mis;
  end

  // ---------------------------------------------------------------
  // Channel mask
  // ---------------------------------------------------------------
  // Set wins over clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_r <= lieb_pkg::CHAN_RESET;
    end else if (wr_at(wb_adr_i, lieb_pkg::CHAN_LOW_SET_OFS, wr_stb)) begin
      chan_r <= chan_r | wmask;                                                    // RQ2
    end else if (wr_at(wb_adr_i, lieb_pkg::CHAN_LOW_CLR_OFS, wr_stb)) begin
      chan_r <= chan_r & ~wmask;                                                   // RQ16
    end
  end

  // ---------------------------------------------------------------
  // Event register
  // ---------------------------------------------------------------
  // Clears only by software; hardware sets win over clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_r <= lieb_pkg::EVENT_RESET;
    end else begin
      event_r <= ((event_r &
                  ~(wr_at(wb_adr_i, lieb_pkg::EVENT_CLR_OFS, wr_stb) ? wmask : 32'h0000_0000)) | // RQ4
                  (wr_at(wb_adr_i, lieb_pkg::EVENT_SET_OFS, wr_stb) ? wmask : 32'h0000_0000) |  // RQ3
                  hw_set) & lieb_pkg::EVENT_LATCH_MASK;                                          // RQ6
    end
  end

  // Event mask, plain read/write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= lieb_pkg::MASK_RESET;
    end else if (wr_at(wb_adr_i, lieb_pkg::EVENT_MASK_OFS, wr_stb)) begin
      mask_r <= (mask_r & ~sel_mask(wb_sel_i)) | wmask;
    end
  end

  // Control bits; overrun drops cycle root enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= 2'h0;
    end else begin
      if (wr_at(wb_adr_i, lieb_pkg::CTRL_OFS, wr_stb) && wb_sel_i[0]) begin
        ctrl_r <= wb_dat_i[1:0];
      end
      // Later assignment wins: an overrun beats a write of the root bit, other bits still land
      if (hw_over) begin
        ctrl_r[lieb_pkg::CTRL_ROOT_EN_BIT] <= 1'b0;                                // RQ11
      end
    end
  end

  // Contexts that faulted are held while the fatal bit stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_ctx_r <= '0;
    end else if (!event_r[lieb_pkg::FATAL_BIT] && !hw_fatal) begin
      fault_ctx_r <= ctx_fault_i;
    end else begin
      fault_ctx_r <= fault_ctx_r | ctx_fault_i;
    end
  end

  // Normal context events gated by fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctx_event_o <= '0;
    end else begin
      ctx_event_o <= ctx_event_i & ~(event_r[lieb_pkg::FATAL_BIT] ? fault_ctx_r : '0); // RQ13
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, enable and output
  // ---------------------------------------------------------------
  // One status bit per event: tardy, phy, overrun, fatal, mismatch, soft
  assign hw_vec = {hw_tardy, hw_phy, hw_over, hw_fatal, hw_mis,
                   wr_at(wb_adr_i, lieb_pkg::EVENT_SET_OFS, wr_stb) && wmask[lieb_pkg::SOFT_BIT]};

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r &
                    ~(wr_at(wb_adr_i, lieb_pkg::IRQ_CLR_OFS, wr_stb) ?
                      wmask[lieb_pkg::IRQ_W-1:0] : '0)) | hw_vec;
    end
  end

  // Enable bits, written from the low byte lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_r <= '0;
    end else if (wr_at(wb_adr_i, lieb_pkg::IRQ_EN_OFS, wr_stb) && wb_sel_i[0]) begin
      irq_en_r <= wb_dat_i[lieb_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt while any enabled status bit stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_en_r);
    end
  end

  // ---------------------------------------------------------------
  // Outputs and read path
  // ---------------------------------------------------------------
  // Registered copies of mask and control bits; phy byte captured on its event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iso_rx_chan_enable_bit_o <= '0;
      cycle_root_enable_o      <= 1'b0;
      late_ack_event_enable_o  <= 1'b0;
      phy_reg_data_o           <= 8'h00;
    end else begin
      iso_rx_chan_enable_bit_o <= chan_r;                                          // RQ1
      cycle_root_enable_o      <= ctrl_r[lieb_pkg::CTRL_ROOT_EN_BIT];
      late_ack_event_enable_o  <= ctrl_r[lieb_pkg::CTRL_TARDY_EN_BIT];
      if (hw_phy) begin
        phy_reg_data_o <= phy_reg_byte_i;                                          // RQ9
      end
    end
  end

  // Read mux; unmapped reads zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      lieb_pkg::CHAN_LOW_SET_OFS, lieb_pkg::CHAN_LOW_CLR_OFS: rd_nxt = chan_r;   // RQ2
      lieb_pkg::EVENT_SET_OFS, lieb_pkg::EVENT_CLR_OFS: begin
        rd_nxt = event_r & mask_r & lieb_pkg::EVENT_LATCH_MASK;                   // RQ5
        rd_nxt[lieb_pkg::ISO_RX_BIT] = (|iso_rx_ctx_masked_i) & mask_r[lieb_pkg::ISO_RX_BIT]; // RQ15
        rd_nxt[lieb_pkg::ISO_TX_BIT] = (|iso_tx_ctx_masked_i) & mask_r[lieb_pkg::ISO_TX_BIT]; // RQ15
      end
      lieb_pkg::EVENT_MASK_OFS: rd_nxt = mask_r;
      lieb_pkg::IRQ_STAT_OFS:   rd_nxt = {26'h0, irq_stat_r};
      lieb_pkg::IRQ_EN_OFS:     rd_nxt = {26'h0, irq_en_r};
      lieb_pkg::CTRL_OFS:       rd_nxt = {30'h0, ctrl_r};
      default:                  rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data loaded on the request edge, standing with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Fatal bit standing with no clear of it in this cycle
  sequence s_fatal_kept;
    event_r[lieb_pkg::FATAL_BIT] &&
    !(wr_stb && wb_adr_i == lieb_pkg::EVENT_CLR_OFS && wmask[lieb_pkg::FATAL_BIT]);
  endsequence

  // Accepted write at one offset
  sequence s_wr_at(logic [7:0] ofs);
    wr_stb && wb_adr_i == ofs;
  endsequence

  // Accepted read of the event register at either address
  sequence s_evt_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    (wb_adr_i == lieb_pkg::EVENT_SET_OFS || wb_adr_i == lieb_pkg::EVENT_CLR_OFS);
  endsequence

  chk_event_sticky: assert property (s_fatal_kept |=> event_r[lieb_pkg::FATAL_BIT]) // RQ4
    else $error("event bit lost without clear");
  chk_phy_set: assert property (hw_phy |=> event_r[lieb_pkg::PHYREG_BIT]) // RQ9
    else $error("phy byte event not latched");
  chk_overrun_root: assert property (hw_over |=> !ctrl_r[lieb_pkg::CTRL_ROOT_EN_BIT] ##1 // RQ11
    !cycle_root_enable_o) else $error("root enable not dropped");
  chk_overrun_gate: assert property (!ctrl_r[lieb_pkg::CTRL_ROOT_EN_BIT] |-> !hw_over) // RQ10
    else $error("overrun without root enable");
  chk_reserved_zero: assert property ((event_r & ~lieb_pkg::EVENT_LATCH_MASK) == 32'h0) // RQ6
    else $error("reserved event bit set");
  chk_chan_set: assert property (wr_stb && wb_adr_i == lieb_pkg::CHAN_LOW_SET_OFS |=> // RQ2
    ((chan_r & $past(wmask)) == $past(wmask))) else $error("channel set failed");
  chk_chan_out: assert property (##1 iso_rx_chan_enable_bit_o == $past(chan_r)) // RQ1
    else $error("channel enable mismatch");
  chk_mismatch_set: assert property (hw_mis |=> event_r[lieb_pkg::MISMATCH_BIT]) // RQ14
    else $error("mismatch not latched");
  chk_soft_nohw: assert property (!hw_set[lieb_pkg::SOFT_BIT]) // RQ7
    else $error("hardware drove soft bit");
  chk_fault_block: assert property (event_r[lieb_pkg::FATAL_BIT] |=> // RQ13
    ((ctx_event_o & $past(fault_ctx_r)) == '0)) else $error("faulted context event passed");

  // Software set and clear of event bits and hardware latching; hardware sets win
  chk_event_set: assert property (s_wr_at(lieb_pkg::EVENT_SET_OFS) |=> // RQ3
    ((event_r & $past(wmask) & lieb_pkg::EVENT_LATCH_MASK) == ($past(wmask) & lieb_pkg::EVENT_LATCH_MASK)))
    else $error("event set write lost");
  chk_event_clear: assert property (s_wr_at(lieb_pkg::EVENT_CLR_OFS) |=> // RQ4
    ((event_r & $past(wmask) & ~$past(hw_set)) == 32'h0)) else $error("event clear write lost");
  chk_event_hold: assert property (!wr_at(wb_adr_i, lieb_pkg::EVENT_CLR_OFS, wr_stb) |=> // RQ4
    ((event_r & $past(event_r)) == $past(event_r))) else $error("event bit dropped");
  chk_tardy_set: assert property (hw_tardy |=> event_r[lieb_pkg::TARDY_BIT]) // RQ8
    else $error("late ack event not latched");
  chk_fatal_set: assert property (hw_fatal |=> event_r[lieb_pkg::FATAL_BIT]) // RQ12
    else $error("fatal stop event not latched");
  chk_phy_byte: assert property (hw_phy |=> phy_reg_data_o == $past(phy_reg_byte_i)) // RQ9
    else $error("phy byte not captured");

  // Channel mask clears and holds
  chk_chan_clear: assert property (s_wr_at(lieb_pkg::CHAN_LOW_CLR_OFS) |=> // RQ16
    ((chan_r & $past(wmask)) == 32'h0)) else $error("channel clear failed");
  chk_chan_hold: assert property (!wr_at(wb_adr_i, lieb_pkg::CHAN_LOW_SET_OFS, wr_stb) && // RQ16
    !wr_at(wb_adr_i, lieb_pkg::CHAN_LOW_CLR_OFS, wr_stb) |=> $stable(chan_r)) else $error("channel mask changed");

  // Event register reads
  chk_event_read: assert property (s_evt_read |=> // RQ5
    ((wb_dat_o & lieb_pkg::EVENT_LATCH_MASK) == $past(event_r & mask_r))) else $error("event read not masked");
  chk_reserved_read: assert property (s_evt_read |=> // RQ6
    ((wb_dat_o & ~lieb_pkg::EVENT_LATCH_MASK & 32'hff80_0000) == 32'h0)) else $error("reserved bit read set");
  chk_iso_read: assert property (s_evt_read |=> // RQ15
    (wb_dat_o[lieb_pkg::ISO_RX_BIT] == $past((|iso_rx_ctx_masked_i) && mask_r[lieb_pkg::ISO_RX_BIT])))
    else $error("iso summary read wrong");

  // Bus answer: one ack per request, one cycle long
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // Status bits stay until cleared
  chk_irq_sticky: assert property (!wr_at(wb_adr_i, lieb_pkg::IRQ_CLR_OFS, wr_stb) |=>
    ((irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r))) else $error("status bit dropped");

endmodule

`default_nettype wire

// ==== lieb_top_tb.sv ====
// Self-checking testbench for the link interrupt event bank
`timescale 1ns/1ps
`default_nettype none
module lieb_top_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                     clk_i, rst_i, cyc, stb, we, ack, root, late, irq;
  logic [7:0]               adr, pb, pd;
  logic [31:0]              wd, rdat, rd, chan, rxm, txm, r, ev, mk, e;
  logic [3:0]               flt, cev, ceo, sel;
  lieb_pkg::lieb_src_s      src;
  lieb_pkg::lieb_cyc_time_s rxt, lct;
  int                       n_errors, n_checks, j;
  int                       ebit [7] = '{23, 24, 25, 26, 27, 27, 27};

  // Design under test
  lieb_top #(.CTX_N(4)) lieb_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .src_i(src), .phy_reg_byte_i(pb), .rx_cycle_time_i(rxt), .local_cycle_time_i(lct),
    .ctx_fault_i(flt), .ctx_event_i(cev), .iso_rx_ctx_masked_i(rxm), .iso_tx_ctx_masked_i(txm),
    .iso_rx_chan_enable_bit_o(chan), .cycle_root_enable_o(root), .late_ack_event_enable_o(late),
    .phy_reg_data_o(pd), .ctx_event_o(ceo), .irq_o(irq)
  );

  // Clock at 100 MHz
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Event read value: latched bits plus live iso summaries, masked
  function automatic logic [31:0] exp_ev(input logic [31:0] v, m, rx, tx);
    return (v | {24'h0, |rx, |tx, 6'h0}) & m;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, g);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  // Classic single Wishbone cycle, held until one cycle after ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      n_errors++;
      $display("[FAIL] ack expected 1 seen %b", ack);
      wrap_up();
    end
    rd = rdat;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Let registered outputs settle before the caller looks at them
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    chk(n, x, rd);
  endtask

  task automatic evchk(input string n);
    wb(1'b0, lieb_pkg::EVENT_CLR_OFS, 32'h0);
    chk(n, exp_ev(ev, mk, rxm, txm), rd);
  endtask

  // One-cycle rising edge on one event source
  task automatic pulse(input int b);
    @(posedge clk_i);
    src <= 7'(7'h1 << b);
    @(posedge clk_i);
    src <= '0;
    @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wd, src, pb, rxt, lct, flt, cev, rxm, txm} = '0;
    sel = 4'hf;
    {ev, mk, n_errors, n_checks} = '0;
    r = 32'h4ba7842c;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("chan_rst", lieb_pkg::CHAN_LOW_SET_OFS, 32'h0);
    evchk("ev_rst");
    $display("test reset done");
    // Random set and clear patterns on the channel mask
    e = '0;
    for (j = 0; j < 4; j++) begin
      r = lfsr(r);
      e = e | r;
      wb(1'b1, lieb_pkg::CHAN_LOW_SET_OFS, r);
      rdchk("chan_set", lieb_pkg::CHAN_LOW_CLR_OFS, e);
      r = lfsr(r);
      e = e & ~r;
      wb(1'b1, lieb_pkg::CHAN_LOW_CLR_OFS, r);
      rdchk("chan_clr", lieb_pkg::CHAN_LOW_SET_OFS, e);
      chk("chan_out", e, chan);
    end
    // Only byte lane 1 of a full set write takes effect
    sel <= 4'h2;
    wb(1'b1, lieb_pkg::CHAN_LOW_SET_OFS, 32'hffffffff);
    sel <= 4'hf;
    e = e | 32'h0000ff00;
    rdchk("chan_lane", lieb_pkg::CHAN_LOW_SET_OFS, e);
    $display("test channel mask done");
    // Software set, clear and masking of event bits
    mk = 32'hffffffff;
    wb(1'b1, lieb_pkg::EVENT_MASK_OFS, mk);
    wb(1'b1, lieb_pkg::EVENT_SET_OFS, 32'hffffffff);
    ev = lieb_pkg::EVENT_LATCH_MASK;
    evchk("ev_set_all");
    for (j = 0; j < 3; j++) begin
      r = lfsr(r);
      mk = r;
      wb(1'b1, lieb_pkg::EVENT_MASK_OFS, mk);
      rdchk("mask_rd", lieb_pkg::EVENT_MASK_OFS, mk);
      evchk("ev_masked");
      r = lfsr(r);
      wb(1'b1, lieb_pkg::EVENT_CLR_OFS, r);
      ev = ev & ~r;
      evchk("ev_clr");
      r = lfsr(r);
      wb(1'b1, lieb_pkg::EVENT_SET_OFS, r);
      ev = ev | (r & lieb_pkg::EVENT_LATCH_MASK);
      evchk("ev_set");
    end
    mk = 32'hffffffff;
    wb(1'b1, lieb_pkg::EVENT_MASK_OFS, mk);
    wb(1'b1, lieb_pkg::EVENT_CLR_OFS, 32'hffffffff);
    $display("test software events done");
    // Each hardware source latches its event bit (bit 27 for all three late ack sources), held after the source falls
    wb(1'b1, lieb_pkg::CTRL_OFS, 32'h3);
    chk("ctrl_out", 32'h3, {30'h0, root, late});
    rdchk("ctrl_rd", lieb_pkg::CTRL_OFS, 32'h3);
    r = lfsr(r);
    pb <= r[7:0];
    rxt <= r[19:0];
    lct <= ~r[19:0];
    flt <= 4'h3;
    cev <= 4'hf;
    for (j = 6; j >= 0; j--) begin
      pulse(j);
      ev = 32'h1 << ebit[j];
      evchk("ev_hw");
      if (j == 1) chk("ctx_block", 32'hc, {28'h0, ceo});
      wb(1'b1, lieb_pkg::EVENT_CLR_OFS, ev);
    end
    chk("root_cleared", 32'h1, {30'h0, root, late});
    chk("phy_byte", {24'h0, pb}, {24'h0, pd});
    chk("ctx_free", 32'hf, {28'h0, ceo});
    // Sources other than phy and fatal, with enables off and equal cycle times, set nothing
    wb(1'b1, lieb_pkg::CTRL_OFS, 32'h0);
    lct <= rxt;
    ev = '0;
    for (j = 6; j >= 0; j--) begin
      if (j != 3 && j != 1) pulse(j);
    end
    evchk("ev_gated");
    $display("test hardware events done");
    // Interrupt status, enable and clear
    wb(1'b1, lieb_pkg::IRQ_CLR_OFS, 32'h3f);
    wb(1'b1, lieb_pkg::IRQ_EN_OFS, 32'h0);
    pulse(3);
    rdchk("irq_stat", lieb_pkg::IRQ_STAT_OFS, 32'h10);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wb(1'b1, lieb_pkg::IRQ_EN_OFS, 32'h10);
    rdchk("irq_en_rd", lieb_pkg::IRQ_EN_OFS, 32'h10);
    chk("irq_on", 32'h1, {31'h0, irq});
    wb(1'b1, lieb_pkg::IRQ_CLR_OFS, 32'h10);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wb(1'b1, lieb_pkg::EVENT_CLR_OFS, 32'hffffffff);
    $display("test interrupt done");
    // Iso summaries follow their inputs without latching
    r = lfsr(r);
    rxm <= r | 32'h1;
    evchk("iso_rx");
    rxm <= '0;
    txm <= r | 32'h1;
    evchk("iso_tx");
    mk = 32'hffffffbf;
    wb(1'b1, lieb_pkg::EVENT_MASK_OFS, mk);
    evchk("iso_mask");
    $display("test iso summary done");
    // Unmapped address: write ignored, read zero, still acknowledged
    wb(1'b1, 8'h40, r);
    rdchk("unmapped", 8'h40, 32'h0);
    $display("test unmapped done");
    wrap_up();
  end
endmodule
`default_nettype wire
